//--- rtl/ijl_map.svh
// register offsets, field positions, reset values and timing counts of the config loader
`ifndef IJL_MAP_SVH
`define IJL_MAP_SVH

`define IJL_ADDR_W 5
`define IJL_OFS_UNLOCK 5'h0d
`define IJL_OFS_EE_CTRL 5'h10
`define IJL_OFS_EE_DATA 5'h11
`define IJL_OFS_STEP 5'h12
`define IJL_OFS_SETTING 5'h13
`define IJL_RESTART_HI 2'h3

`define IJL_UNLOCK_BIT 7
`define IJL_SK_BIT 6
`define IJL_CS_BIT 5
`define IJL_DIO_BIT 7
`define IJL_CFG_INT_HI 7
`define IJL_CFG_INT_LO 6
`define IJL_CFG_BASE_HI 2
`define IJL_CFG_BASE_LO 0

`define IJL_UNLOCK_RST 1'b1
`define IJL_CFG_RST 5'h00

`define IJL_EE_ADDR_BITS 6
`define IJL_CLK_NS 20
`define IJL_SK_HALF_NS 1000
`define IJL_SK_HALF_CYC ((`IJL_SK_HALF_NS + `IJL_CLK_NS - 1) / `IJL_CLK_NS)
`define IJL_INIT_US 50
`define IJL_INIT_CYC ((`IJL_INIT_US * 1000) / `IJL_CLK_NS)

`endif

//--- rtl/ijl_pkg.sv
// types used by the config loader top module
`default_nettype none
package ijl_pkg;

  typedef enum logic [2:0] {
    IJL_ST_START = 3'b001,
    IJL_ST_LOAD = 3'b010,
    IJL_ST_READY = 3'b100
  } ijl_state_t;

  typedef struct packed {
    logic [1:0] int_sel;
    logic [2:0] base_sel;
  } ijl_cfg_t;

endpackage
`default_nettype wire

//--- rtl/ijl_ee_reader.sv
// serial eeprom reader that fetches the configuration byte at address zero
`include "ijl_map.svh"
`default_nettype none
module ijl_ee_reader #(
  parameter int unsigned ADDR_BITS = `IJL_EE_ADDR_BITS,
  parameter int unsigned HALF_CYC = `IJL_SK_HALF_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clr_in,
  input wire logic start_in,
  input wire logic do_in,
  output logic sk_out,
  output logic cs_out,
  output logic di_out,
  output logic busy_out,
  output logic done_out,
  output logic [7:0] data_out
);
  localparam int unsigned CMD_LEN = 3 + ADDR_BITS;
  localparam int unsigned TOTAL = CMD_LEN + 8;
  // start bit, read opcode, then address zero: only the first byte holds configuration
  localparam logic [CMD_LEN-1:0] READ_CMD = {3'b110, {ADDR_BITS{1'b0}}};

  logic busy_r, busy_nxt;
  logic sk_r, sk_nxt;
  logic done_r, done_nxt;
  logic [CMD_LEN-1:0] cmd_r, cmd_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [5:0] bit_r, bit_nxt;
  logic [15:0] div_r, div_nxt;

  always_comb begin
    busy_nxt = busy_r;
    sk_nxt = sk_r;
    done_nxt = 1'b0;
    cmd_nxt = cmd_r;
    shift_nxt = shift_r;
    bit_nxt = bit_r;
    div_nxt = div_r;
    if (clr_in) begin
      busy_nxt = 1'b0;
      sk_nxt = 1'b0;
      cmd_nxt = '0;
      bit_nxt = '0;
      div_nxt = '0;
    end else if (start_in && !busy_r) begin
      busy_nxt = 1'b1;
      sk_nxt = 1'b0;
      cmd_nxt = READ_CMD;
      bit_nxt = '0;
      div_nxt = '0;
    end else if (busy_r) begin
      if (div_r == 16'(HALF_CYC - 1)) begin
        div_nxt = '0;
        if (!sk_r) begin
          sk_nxt = 1'b1;
        end else begin
          // data is sampled on the falling edge, well after the part has driven it
          sk_nxt = 1'b0;
          cmd_nxt = {cmd_r[CMD_LEN-2:0], 1'b0};
          if (bit_r >= 6'(CMD_LEN)) begin
            shift_nxt = {shift_r[6:0], do_in};
          end
          if (bit_r == 6'(TOTAL - 1)) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
          end else begin
            bit_nxt = bit_r + 6'd1;
          end
        end
      end else begin
        div_nxt = div_r + 16'd1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_r <= 1'b0;
      sk_r <= 1'b0;
      done_r <= 1'b0;
      cmd_r <= '0;
      shift_r <= '0;
      bit_r <= '0;
      div_r <= '0;
    end else begin
      busy_r <= busy_nxt;
      sk_r <= sk_nxt;
      done_r <= done_nxt;
      cmd_r <= cmd_nxt;
      shift_r <= shift_nxt;
      bit_r <= bit_nxt;
      div_r <= div_nxt;
    end
  end

  assign sk_out = sk_r;
  assign cs_out = busy_r;
  assign di_out = cmd_r[CMD_LEN-1];
  assign busy_out = busy_r;
  assign done_out = done_r;
  assign data_out = shift_r;
endmodule
`default_nettype wire

//--- rtl/ijl_config_loader.sv
// top of the jumperless configuration loader: register port, eeprom load, base and interrupt select
//
// Added by the designer: the plain strobed port and the register offsets.
`include "ijl_map.svh"
`default_nettype none
module ijl_config_loader #(
  parameter int unsigned EE_ADDR_BITS = `IJL_EE_ADDR_BITS,
  parameter int unsigned INIT_CYC = `IJL_INIT_CYC
) (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic [4:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic JUMPER_MODE_IN,
  input wire logic [2:0] JUMPER_BASE_IN,
  input wire logic EE_DO_IN,
  input wire logic INT_REQ_IN,
  output logic [7:0] REG_RDATA_OUT,
  output logic EE_SK_OUT,
  output logic EE_CS_OUT,
  output logic EE_DI_OUT,
  output logic [3:0] IRQ_OUT,
  output logic [2:0] BASE_SEL_OUT,
  output logic CORE_RESET_OUT
);

  function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
    hit = (addr == ofs);
  endfunction

  function automatic logic [3:0] irq_decode(input logic [1:0] sel);
    irq_decode = 4'h1 << sel;
  endfunction

  // eeprom pins: the loader owns them while it runs, software the rest of the time
  function automatic logic pick(input logic use_rd, input logic rd_v, input logic sw_v);
    pick = use_rd ? rd_v : sw_v;
  endfunction

  // the restart registers fill the top quarter of the map, so only the two top address bits decode
  function automatic logic restart_hit(input logic [4:0] addr);
    restart_hit = (addr[4:3] == `IJL_RESTART_HI);
  endfunction

  // bus decode
  // a strobe acts only in the cycle it is high, so no access is ever half taken
  logic wr_unlock;
  logic wr_ctrl;
  logic wr_data;
  logic wr_restart;
  logic rd_step;

  assign wr_unlock = REG_WR_IN && hit(REG_ADDR_IN, `IJL_OFS_UNLOCK);
  assign wr_ctrl = REG_WR_IN && hit(REG_ADDR_IN, `IJL_OFS_EE_CTRL);
  assign wr_data = REG_WR_IN && hit(REG_ADDR_IN, `IJL_OFS_EE_DATA);
  assign wr_restart = REG_WR_IN && restart_hit(REG_ADDR_IN);
  assign rd_step = REG_RD_IN && hit(REG_ADDR_IN, `IJL_OFS_STEP);

  // software eeprom port; only the hard reset clears it, a restart leaves it alone
  logic sw_sk_r, sw_sk_nxt;
  logic sw_cs_r, sw_cs_nxt;
  logic sw_di_r, sw_di_nxt;

  always_comb begin
    sw_sk_nxt = sw_sk_r;
    sw_cs_nxt = sw_cs_r;
    sw_di_nxt = sw_di_r;
    if (wr_ctrl) begin
      sw_sk_nxt = REG_WDATA_IN[`IJL_SK_BIT];
      sw_cs_nxt = REG_WDATA_IN[`IJL_CS_BIT];
    end
    if (wr_data) begin
      sw_di_nxt = REG_WDATA_IN[`IJL_DIO_BIT];
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      sw_sk_r <= 1'b0;
      sw_cs_r <= 1'b0;
      sw_di_r <= 1'b0;
    end else begin
      sw_sk_r <= sw_sk_nxt;
      sw_cs_r <= sw_cs_nxt;
      sw_di_r <= sw_di_nxt;
    end
  end

  // eeprom reader
  // its busy flag is left open: the load state already says when the pins belong to it
  logic rd_start;
  logic rd_clr;
  logic rd_sk;
  logic rd_cs;
  logic rd_di;
  logic rd_done;
  logic [7:0] rd_data;

  ijl_ee_reader #(
    .ADDR_BITS(EE_ADDR_BITS),
    .HALF_CYC(`IJL_SK_HALF_CYC)
  ) u_reader (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .clr_in(rd_clr),
    .start_in(rd_start),
    .do_in(EE_DO_IN),
    .sk_out(rd_sk),
    .cs_out(rd_cs),
    .di_out(rd_di),
    .busy_out(),
    .done_out(rd_done),
    .data_out(rd_data)
  );

  // configuration state
  ijl_pkg::ijl_state_t state_r, state_nxt;
  ijl_pkg::ijl_cfg_t cfg_r, cfg_nxt;
  ijl_pkg::ijl_cfg_t eff_cfg;
  logic jumper_r, jumper_nxt;
  logic unlock_r, unlock_nxt;
  logic [15:0] init_cnt_r, init_cnt_nxt;
  logic load_late;

  // the deadline bounds how long the core is held even if the eeprom never answers
  assign load_late = (state_r == ijl_pkg::IJL_ST_LOAD) && (init_cnt_r == 16'(INIT_CYC - 1));

  always_comb begin
    state_nxt = state_r;
    cfg_nxt = cfg_r;
    jumper_nxt = jumper_r;
    rd_start = 1'b0;
    rd_clr = 1'b0;
    if (wr_restart) begin
      state_nxt = ijl_pkg::IJL_ST_START;
      cfg_nxt = `IJL_CFG_RST;
      rd_clr = 1'b1;
    end else begin
      case (state_r)
        ijl_pkg::IJL_ST_START: begin
          // mode strap is caught here, after the reset release
          jumper_nxt = JUMPER_MODE_IN;
          // jumper mode has nothing to load, so it is ready at once
          if (JUMPER_MODE_IN) begin
            state_nxt = ijl_pkg::IJL_ST_READY;
          end else begin
            rd_start = 1'b1;
            state_nxt = ijl_pkg::IJL_ST_LOAD;
          end
        end
        ijl_pkg::IJL_ST_LOAD: begin
          if (rd_done) begin
            cfg_nxt.int_sel = rd_data[`IJL_CFG_INT_HI:`IJL_CFG_INT_LO];
            cfg_nxt.base_sel = rd_data[`IJL_CFG_BASE_HI:`IJL_CFG_BASE_LO];
            state_nxt = ijl_pkg::IJL_ST_READY;
          end else if (load_late) begin
            rd_clr = 1'b1;
            state_nxt = ijl_pkg::IJL_ST_READY;
          end
        end
        ijl_pkg::IJL_ST_READY: begin
          // stepping only moves the base, never the interrupt pin
          if (rd_step && !jumper_r && unlock_r) begin
            cfg_nxt.base_sel = cfg_r.base_sel + 3'd1;
          end
        end
        default: begin
          state_nxt = ijl_pkg::IJL_ST_START;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_r <= ijl_pkg::IJL_ST_START;
      cfg_r <= `IJL_CFG_RST;
      jumper_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cfg_r <= cfg_nxt;
      jumper_r <= jumper_nxt;
    end
  end

  // a restart sets the unlock bit again, so a base locked at the wrong place can be freed
  always_comb begin
    unlock_nxt = unlock_r;
    if (wr_restart) begin
      unlock_nxt = `IJL_UNLOCK_RST;
    end else if (wr_unlock) begin
      unlock_nxt = REG_WDATA_IN[`IJL_UNLOCK_BIT];
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      unlock_r <= `IJL_UNLOCK_RST;
    end else begin
      unlock_r <= unlock_nxt;
    end
  end

  // deadline counter runs only while loading and starts from zero on every new load
  always_comb begin
    init_cnt_nxt = '0;
    if (!wr_restart && (state_r == ijl_pkg::IJL_ST_LOAD)) begin
      init_cnt_nxt = init_cnt_r + 16'd1;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      init_cnt_r <= '0;
    end else begin
      init_cnt_r <= init_cnt_nxt;
    end
  end

  // effective selection: jumper mode takes the pins and pins irq to the first output
  always_comb begin
    eff_cfg = cfg_r;
    if (jumper_r) begin
      eff_cfg.base_sel = JUMPER_BASE_IN;
      eff_cfg.int_sel = 2'h0;
    end
  end

  // register read data, valid only in the cycle after the read strobe
  logic [7:0] rdata_r, rdata_nxt;

  always_comb begin
    rdata_nxt = 8'h00;
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        `IJL_OFS_UNLOCK: begin
          rdata_nxt = {unlock_r, 7'h00};
        end
        `IJL_OFS_EE_CTRL: begin
          rdata_nxt = {1'b0, sw_sk_r, sw_cs_r, 5'h00};
        end
        `IJL_OFS_EE_DATA: begin
          rdata_nxt = {EE_DO_IN, 7'h00};
        end
        `IJL_OFS_STEP: begin
          rdata_nxt = 8'h00;
        end
        `IJL_OFS_SETTING: begin
          rdata_nxt = {eff_cfg.int_sel, 3'h0, eff_cfg.base_sel};
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  // read data stand for exactly one cycle and are zero otherwise
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // pin registers; all outputs leave from flops so the pins never glitch on the mux
  logic ee_sk_r, ee_sk_nxt;
  logic ee_cs_r, ee_cs_nxt;
  logic ee_di_r, ee_di_nxt;
  logic [3:0] irq_r, irq_nxt;
  logic [2:0] base_r, base_nxt;
  logic core_rst_r, core_rst_nxt;
  logic loading;

  assign loading = (state_r == ijl_pkg::IJL_ST_LOAD);

  always_comb begin
    ee_sk_nxt = pick(loading, rd_sk, sw_sk_r);
    ee_cs_nxt = pick(loading, rd_cs, sw_cs_r);
    ee_di_nxt = pick(loading, rd_di, sw_di_r);
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ee_sk_r <= 1'b0;
      ee_cs_r <= 1'b0;
      ee_di_r <= 1'b0;
    end else begin
      ee_sk_r <= ee_sk_nxt;
      ee_cs_r <= ee_cs_nxt;
      ee_di_r <= ee_di_nxt;
    end
  end

  // interrupt pins stay quiet until the selection is final, so no stale pin fires during a load
  always_comb begin
    irq_nxt = 4'h0;
    if (INT_REQ_IN && (state_r == ijl_pkg::IJL_ST_READY)) begin
      irq_nxt = irq_decode(eff_cfg.int_sel);
    end
    // the base pins follow the effective selection one cycle later
    base_nxt = eff_cfg.base_sel;
    core_rst_nxt = (state_nxt != ijl_pkg::IJL_ST_READY);
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      irq_r <= 4'h0;
      base_r <= 3'h0;
      core_rst_r <= 1'b1;
    end else begin
      irq_r <= irq_nxt;
      base_r <= base_nxt;
      core_rst_r <= core_rst_nxt;
    end
  end

  assign REG_RDATA_OUT = rdata_r;
  assign EE_SK_OUT = ee_sk_r;
  assign EE_CS_OUT = ee_cs_r;
  assign EE_DI_OUT = ee_di_r;
  assign IRQ_OUT = irq_r;
  assign BASE_SEL_OUT = base_r;
  assign CORE_RESET_OUT = core_rst_r;

endmodule
`default_nettype wire

//--- bench/ijl_ee_model.sv
// behavioural serial eeprom serving the configuration byte at address zero
`default_nettype none
module ijl_ee_model (
  input wire logic clk_in,
  input wire logic sk_in,
  input wire logic cs_in,
  input wire logic di_in,
  input wire logic [7:0] byte_in,
  output logic do_out,
  output logic [8:0] cmd_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  logic tog = 1'b0;
  // unselected output toggles so a stale bit never passes for data
  always @(posedge clk_in) tog <= ~tog;
  always @(posedge sk_in or negedge cs_in) begin
    if (!cs_in)
      n <= 0;
    else begin
      if (n < 9)
        cmd_out <= {cmd_out[7:0], di_in};
      n <= n + 1;
    end
  end
  // data leave msb first from the tenth clock on; only byte zero is served
  assign do_out = !cs_in ? tog : (n >= 10 && n <= 17) ? byte_in[17 - n] : 1'b1;
endmodule
`default_nettype wire

//--- bench/ijl_config_loader_checker.sv
// port assertions for the config loader, bound into its top module
`include "ijl_map.svh"
`default_nettype none
module ijl_config_loader_checker (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic [4:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic JUMPER_MODE_IN,
  input wire logic [2:0] JUMPER_BASE_IN,
  input wire logic EE_DO_IN,
  input wire logic INT_REQ_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic EE_SK_OUT,
  input wire logic EE_CS_OUT,
  input wire logic EE_DI_OUT,
  input wire logic [3:0] IRQ_OUT,
  input wire logic [2:0] BASE_SEL_OUT,
  input wire logic CORE_RESET_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int INIT_MAX = `IJL_INIT_CYC;
  logic restart;
  logic rdy;
  logic step;
  logic unl_r;
  logic unl_nxt;
  logic rs_r;
  logic rs_nxt;
  assign restart = REG_WR_IN && REG_ADDR_IN[4:3] == `IJL_RESTART_HI;
  // the restart cycle itself still shows the old reset level
  assign rdy = !CORE_RESET_OUT && !restart && !rs_r;
  assign step = REG_RD_IN && REG_ADDR_IN == `IJL_OFS_STEP && rdy && !JUMPER_MODE_IN;
  always_comb begin
    rs_nxt = restart;
    unl_nxt = unl_r;
    if (restart)
      unl_nxt = 1'b1;
    else if (REG_WR_IN && REG_ADDR_IN == `IJL_OFS_UNLOCK)
      unl_nxt = REG_WDATA_IN[`IJL_UNLOCK_BIT];
  end
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      unl_r <= 1'b1;
      rs_r <= 1'b0;
    end else begin
      unl_r <= unl_nxt;
      rs_r <= rs_nxt;
    end
  end
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  step_data_a: assert property (REG_RD_IN && REG_ADDR_IN == `IJL_OFS_STEP |=> REG_RDATA_OUT == 8'h00)
    else $error("step read returned data");
  step_inc_a: assert property (step && unl_r |-> ##2 BASE_SEL_OUT == $past(BASE_SEL_OUT) + 3'h1)
    else $error("step read did not advance base");
  step_lock_a: assert property (step && !unl_r |-> ##2 $stable(BASE_SEL_OUT))
    else $error("locked base moved");
  setting_a: assert property (REG_RD_IN && REG_ADDR_IN == `IJL_OFS_SETTING |=>
    REG_RDATA_OUT[5:0] == {3'h0, BASE_SEL_OUT})
    else $error("setting read disagrees with base");
  jmp_base_a: assert property (JUMPER_MODE_IN && rdy |=> BASE_SEL_OUT == $past(JUMPER_BASE_IN))
    else $error("jumper base not from pins");
  jmp_irq_a: assert property (JUMPER_MODE_IN && rdy |=> IRQ_OUT == {3'h0, $past(INT_REQ_IN)})
    else $error("jumper irq not on first pin");
  init_time_a: assert property ($rose(RESET_N_IN) |-> ##[1:INIT_MAX] !CORE_RESET_OUT)
    else $error("init too slow after reset");
  restart_a: assert property (restart |-> ##[1:2] CORE_RESET_OUT ##[1:INIT_MAX] !CORE_RESET_OUT)
    else $error("restart did not reinit in time");
endmodule
bind ijl_config_loader ijl_config_loader_checker ijl_config_loader_checker_i (.*);
`default_nettype wire

//--- bench/ijl_config_loader_test.sv
// self-checking bench for the jumperless config loader
`include "ijl_map.svh"
`default_nettype none
module ijl_config_loader_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic jmp = 1'b0;
  logic [2:0] jbase = 3'h0;
  logic int_req = 1'b0;
  logic [7:0] cfg = 8'h00;
  logic ee_do, sk, cs, di, core_rst;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [3:0] irq;
  logic [2:0] base;
  logic [8:0] cmd;
  int n_mismatch = 0;
  int checks = 0;
  int n;
  always #10 clk = ~clk;
  ijl_config_loader #(.INIT_CYC(2000)) ijl_config_loader_i (
    .SYS_CLK_IN(clk),
    .RESET_N_IN(rst_n),
    .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr),
    .REG_RD_IN(rd),
    .JUMPER_MODE_IN(jmp),
    .JUMPER_BASE_IN(jbase),
    .EE_DO_IN(ee_do),
    .INT_REQ_IN(int_req),
    .REG_RDATA_OUT(rdata),
    .EE_SK_OUT(sk),
    .EE_CS_OUT(cs),
    .EE_DI_OUT(di),
    .IRQ_OUT(irq),
    .BASE_SEL_OUT(base),
    .CORE_RESET_OUT(core_rst)
  );
  ijl_ee_model ijl_ee_model_i (.clk_in(clk), .sk_in(sk), .cs_in(cs), .di_in(di), .byte_in(cfg),
    .do_out(ee_do), .cmd_out(cmd));
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_init;
    n = 0;
    while (core_rst !== 1'b0 && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  // mode and pins change only while reset is held
  task automatic hard_reset(input logic m, input logic [2:0] b);
    @(posedge clk);
    rst_n <= 1'b0;
    jmp <= m;
    jbase <= b;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wait_init();
  endtask
  task automatic irq_chk(input logic [3:0] exp);
    @(posedge clk);
    int_req <= 1'b1;
    repeat (2) @(posedge clk);
    int_req <= 1'b0;
    #1 chk(irq, exp);
  endtask
  initial begin
    void'($urandom(32'h171a2ff2));
    for (int i = 0; i < 4; i++) begin
      cfg <= {2'(i), 6'($urandom)};
      hard_reset(1'b0, 3'h0);
      chk({8'h0, n <= 2500}, 9'h1);
      chk(cmd, 9'h180);
      rd_reg(`IJL_OFS_SETTING);
      chk(d, {cfg[7:6], 3'h0, cfg[2:0]});
      irq_chk(4'h1 << i);
    end
    // nine back-to-back steps wrap the three-bit select once
    @(posedge clk);
    rd <= 1'b1;
    addr <= `IJL_OFS_STEP;
    repeat (9) @(posedge clk);
    rd <= 1'b0;
    rd_reg(`IJL_OFS_SETTING);
    chk(d[2:0], 3'(cfg[2:0] + 3'h1));
    wr_reg(`IJL_OFS_UNLOCK, 8'h00);
    rd_reg(`IJL_OFS_UNLOCK);
    chk(d[7], 1'b0);
    rd_reg(`IJL_OFS_STEP);
    rd_reg(`IJL_OFS_SETTING);
    chk(d[2:0], 3'(cfg[2:0] + 3'h1));
    rd_reg(5'h14);
    chk(d, 8'h00);
    wr_reg(`IJL_OFS_EE_CTRL, 8'h60);
    wr_reg(`IJL_OFS_EE_DATA, 8'h80);
    rd_reg(`IJL_OFS_EE_DATA);
    chk({sk, cs, di}, 3'h7);
    chk(d[7], ee_do);
    wr_reg(`IJL_OFS_EE_CTRL, 8'h40);
    cfg <= 8'($urandom);
    wr_reg({`IJL_RESTART_HI, 3'($urandom)}, 8'($urandom));
    repeat (3) @(posedge clk);
    wait_init();
    rd_reg(`IJL_OFS_SETTING);
    chk(d, {cfg[7:6], 3'h0, cfg[2:0]});
    rd_reg(`IJL_OFS_EE_CTRL);
    chk(d[6:5], 2'h2);
    rd_reg(`IJL_OFS_UNLOCK);
    chk(d[7], 1'b1);
    wr_reg(`IJL_OFS_EE_CTRL, 8'h00);
    hard_reset(1'b1, 3'($urandom));
    chk(9'(n), 9'h1);
    rd_reg(`IJL_OFS_STEP);
    repeat (2) @(posedge clk);
    #1 chk({cs, base}, {1'b0, jbase});
    rd_reg(`IJL_OFS_SETTING);
    chk(d, {5'h0, jbase});
    irq_chk(4'h1);
    wr_reg(`IJL_OFS_EE_CTRL, 8'h20);
    rd_reg(`IJL_OFS_EE_CTRL);
    chk({sk, cs}, 2'h1);
    chk(d[6:5], 2'h1);
    give_verdict();
  end
  // about six times the expected run
  initial begin
    #1000000;
    n_mismatch++;
    give_verdict();
  end
endmodule
`default_nettype wire
